// *** include/vcf_pkg.sv ***
// Package: shared types and constants of the field capture DMA
package vcf_pkg;

  // ----------------------------------------------------------------
  // Geometry widths and limits
  // ----------------------------------------------------------------
  localparam int unsigned DIM_W      = 12;
  localparam int unsigned PIX_W      = 24;
  localparam logic [11:0] DIM_NOLIM  = 12'h000;
  localparam logic [11:0] DIM_ONE    = 12'h001;

  // ----------------------------------------------------------------
  // Converter modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VCF_CSC_BYPASS,
    VCF_CSC_RGB_TO_YUV422,
    VCF_CSC_RGB_TO_YUV420,
    VCF_CSC_YUV422_TO_RGB
  } vcf_csc_mode_t;

  // ----------------------------------------------------------------
  // Stream beat, memory write word and output descriptor
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] pixel;
    logic        sof;
    logic        eol;
    logic        field_identifier;
  } vcf_beat_t;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [23:0] pixel;
    logic        field_identifier;
  } vcf_wr_t;

  typedef struct packed {
    logic        field_identifier;
    logic        clipped;
    logic [11:0] lines;
  } vcf_desc_t;

endpackage

// *** logic/vcf_capture_dma.sv ***
// Module: capture parser, inline converter and clipping capture DMA
`timescale 1ns/1ps

module vcf_capture_dma #(
  parameter int unsigned DIM_W = vcf_pkg::DIM_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  src_valid,
  input  wire vcf_pkg::vcf_beat_t    src_beat,
  input  wire logic                  interlaced,
  input  wire vcf_pkg::vcf_csc_mode_t csc_mode,
  input  wire logic [DIM_W-1:0]      max_width,
  input  wire logic [DIM_W-1:0]      max_height,
  input  wire logic                  mem_ready,
  output logic                       src_ready,
  output logic                       parser_field_identifier,
  output logic                       mem_valid,
  output vcf_pkg::vcf_wr_t           mem_wr,
  output logic                       desc_valid,
  output vcf_pkg::vcf_desc_t         desc
);

  if (DIM_W != vcf_pkg::DIM_W)
  begin
    $error("DIM_W must match package width");
  end

  // ----------------------------------------------------------------
  // Capture parser
  // ----------------------------------------------------------------
  logic                  fid_q;
  logic                  take;
  logic                  clip_x;
  logic                  clip_y;
  logic                  keep;
  logic [DIM_W-1:0]      x_q;
  logic [DIM_W-1:0]      y_q;
  logic                  over_q;
  logic                  started_q;
  logic [23:0]           conv;
  vcf_pkg::vcf_wr_t      buf_q [2];
  logic                  wp_q;
  logic                  rp_q;
  logic [1:0]            cnt_q;
  logic [1:0]            cnt_d;
  logic                  fld_csc_q;
  logic                  fld_il_q;

  assign take = src_valid && src_ready;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      fid_q <= 1'b0;
    else if (take && src_beat.sof)
      fid_q <= src_beat.field_identifier;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      parser_field_identifier <= 1'b0;
    else if (take && src_beat.sof)
      parser_field_identifier <= src_beat.field_identifier;
  end

  // ----------------------------------------------------------------
  // Colour space converter (coarse channel mixing)
  // ----------------------------------------------------------------
  always_comb
  begin
    conv = src_beat.pixel;
    case (csc_mode)
      vcf_pkg::VCF_CSC_RGB_TO_YUV422,
      vcf_pkg::VCF_CSC_RGB_TO_YUV420:
        conv = {src_beat.pixel[15:8],
                8'(({1'b0, src_beat.pixel[7:0]} + 9'h080) >> 1),
                8'(({1'b0, src_beat.pixel[23:16]} + 9'h080) >> 1)};
      vcf_pkg::VCF_CSC_YUV422_TO_RGB:
        conv = {src_beat.pixel[7:0], src_beat.pixel[23:16],
                src_beat.pixel[15:8]};
      default:
        conv = src_beat.pixel;
    endcase
  end

  // ----------------------------------------------------------------
  // Position tracking and clipping
  // ----------------------------------------------------------------
  logic [DIM_W-1:0] cx;
  logic [DIM_W-1:0] cy;
  assign cx = src_beat.sof ? '0 : x_q;
  assign cy = src_beat.sof ? '0 : y_q;
  assign clip_x = (max_width != vcf_pkg::DIM_NOLIM) && (cx >= max_width);
  assign clip_y = (max_height != vcf_pkg::DIM_NOLIM) && (cy >= max_height);
  assign keep = !(clip_x || clip_y);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      x_q <= '0;
      y_q <= '0;
    end
    else if (take)
    begin
      x_q <= src_beat.eol ? '0 : cx + vcf_pkg::DIM_ONE;
      y_q <= src_beat.eol ? cy + vcf_pkg::DIM_ONE : cy;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      over_q <= 1'b0;
    else if (take)
      over_q <= (src_beat.sof ? 1'b0 : over_q) || !keep;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      started_q <= 1'b0;
    else if (take && src_beat.sof)
      started_q <= 1'b1;
  end

  // Mode of the field in flight, used when its descriptor goes out
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      fld_csc_q <= 1'b0;
      fld_il_q  <= 1'b0;
    end
    else if (take && src_beat.sof)
    begin
      fld_csc_q <= (csc_mode != vcf_pkg::VCF_CSC_BYPASS);
      fld_il_q  <= interlaced;
    end
  end

  // ----------------------------------------------------------------
  // Descriptor out: issued for previous field at each start of field except the first after reset
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      desc_valid <= 1'b0;
      desc       <= '0;
    end
    else
    begin
      desc_valid <= take && src_beat.sof && started_q;
      if (take && src_beat.sof)
      begin
        desc.lines   <= y_q;
        desc.clipped <= over_q;
        if (fld_csc_q)
          desc.field_identifier <= 1'b0;
        else if (fld_il_q && over_q)
          desc.field_identifier <= 1'b0;
        else
          desc.field_identifier <= fid_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry buffer to memory; writes keep true parity
  // ----------------------------------------------------------------
  logic push;
  logic pop;
  logic wfid;
  assign push = take && keep;
  assign pop  = mem_valid && mem_ready;
  assign wfid = src_beat.sof ? src_beat.field_identifier : fid_q;
  assign cnt_d = 2'(cnt_q + {1'b0, push} - {1'b0, pop});

  always_ff @(posedge ref_clk)
  begin
    if (push)
      buf_q[wp_q] <= '{x: cx, y: cy, pixel: conv,
                       field_identifier: wfid};
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wp_q      <= 1'b0;
      rp_q      <= 1'b0;
      cnt_q     <= 2'h0;
      src_ready <= 1'b1;
    end
    else
    begin
      wp_q      <= wp_q ^ push;
      rp_q      <= rp_q ^ pop;
      cnt_q     <= cnt_d;
      src_ready <= (cnt_d != 2'h2);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mem_valid <= 1'b0;
      mem_wr    <= '0;
    end
    else if (!mem_valid || mem_ready)
    begin
      mem_valid <= (cnt_q != 2'h0) && !(mem_valid && cnt_q == 2'h1);
      mem_wr    <= (mem_valid && cnt_q == 2'h2) ? buf_q[!rp_q] : buf_q[rp_q];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_csc_fid_zero: assert property (@(posedge ref_clk) disable iff (rst)
    desc_valid && $past(fld_csc_q)
    |-> !desc.field_identifier)
    else $error("converter path reported nonzero field identifier");
  chk_clip_fid_zero: assert property (@(posedge ref_clk) disable iff (rst)
    desc_valid && $past(fld_il_q) && desc.clipped
    |-> !desc.field_identifier)
    else $error("clipped interlaced field not reported even");
  chk_write_bounds: assert property (@(posedge ref_clk) disable iff (rst)
    push && max_width != '0 |-> cx < max_width)
    else $error("write beyond programmed width");
  chk_parser_fid: assert property (@(posedge ref_clk) disable iff (rst)
    take && src_beat.sof
    |=> parser_field_identifier == $past(src_beat.field_identifier))
    else $error("parser did not record field identifier");
  chk_bypass_fid: assert property (@(posedge ref_clk) disable iff (rst)
    desc_valid && !desc.clipped
    && !$past(fld_csc_q)
    |-> desc.field_identifier == $past(fid_q))
    else $error("bypass descriptor lost field identifier");
  chk_write_parity: assert property (@(posedge ref_clk) disable iff (rst)
    push && !src_beat.sof |-> wfid == fid_q)
    else $error("written field parity wrong");
  chk_buf_count: assert property (@(posedge ref_clk) disable iff (rst)
    cnt_q != 2'h3)
    else $error("buffer count overflow");
  chk_hold_word: assert property (@(posedge ref_clk) disable iff (rst)
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_wr))
    else $error("write word dropped under stall");

  cov_clip: cover property (@(posedge ref_clk) desc_valid && desc.clipped);
  cov_csc: cover property (@(posedge ref_clk)
    desc_valid && csc_mode != vcf_pkg::VCF_CSC_BYPASS);
  cov_full: cover property (@(posedge ref_clk) cnt_q == 2'h2);
  cov_odd: cover property (@(posedge ref_clk)
    desc_valid && desc.field_identifier);

endmodule

// *** tb/vcf_mem_model.sv ***
// Memory sink model: accepts writes, stalls at random when slow is set
`timescale 1ns/1ps

module vcf_mem_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic slow,
  output logic      mem_ready
);
  always @(posedge ref_clk)
    if (rst)
      mem_ready <= 1'b1;
    else
      mem_ready <= !slow || ($urandom_range(0, 2) == 0);
endmodule

// *** tb/testbench.sv ***
// Testbench: corner and random fields through the capture DMA
`timescale 1ns/1ps

module testbench;
  logic ref_clk, rst, src_valid, interlaced, mem_valid, mem_ready, slow;
  logic src_ready, parser_field_identifier, desc_valid;
  logic [11:0] max_width, max_height;
  vcf_pkg::vcf_beat_t     src_beat;
  vcf_pkg::vcf_csc_mode_t csc_mode;
  vcf_pkg::vcf_wr_t       mem_wr;
  vcf_pkg::vcf_desc_t     desc;
  logic [13:0] exp_q[$];
  logic [47:0] wq[$];
  logic [47:0] exp_w;
  int bad_count, n_tests, words, cyc, fid_now;

  vcf_capture_dma dut (.ref_clk(ref_clk), .rst(rst), .src_valid(src_valid),
    .src_beat(src_beat), .interlaced(interlaced), .csc_mode(csc_mode),
    .max_width(max_width), .max_height(max_height), .mem_ready(mem_ready),
    .src_ready(src_ready), .parser_field_identifier(parser_field_identifier),
    .mem_valid(mem_valid), .mem_wr(mem_wr), .desc_valid(desc_valid),
    .desc(desc));
  vcf_mem_model mem (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .mem_ready(mem_ready));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp,
                     input string m);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Expected descriptor {field_identifier, clipped, lines}
  function automatic logic [13:0] expd(input logic f, input int w, h);
    logic c;
    c = (max_width != 0 && w > max_width);
    c = c || (max_height != 0 && h > max_height);
    if (csc_mode != vcf_pkg::VCF_CSC_BYPASS || (interlaced && c))
      f = 1'b0;
    return {f, c, 12'(h)};
  endfunction

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      summarize();
    end
  end

  always @(posedge ref_clk)
  begin
    if (mem_valid && mem_ready)
    begin
      words++;
      exp_w = (wq.size() > 0) ? wq.pop_front() : '1;
      chk(mem_wr.field_identifier, fid_now, "parity");
      chk({mem_wr.x, mem_wr.y}, exp_w[47:24], "position");
      if (csc_mode == vcf_pkg::VCF_CSC_BYPASS)
        chk(mem_wr.pixel, exp_w[23:0], "pixel");
      if (max_width != 0) chk(mem_wr.x < max_width, 1, "clip x");
      if (max_height != 0) chk(mem_wr.y < max_height, 1, "clip y");
    end
    if (desc_valid && exp_q.size() > 0)
      chk(desc, exp_q.pop_front(), "desc");
  end

  task automatic cfg(input logic il, input int m, mw, mh);
    interlaced <= il;
    csc_mode <= vcf_pkg::vcf_csc_mode_t'(m);
    max_width <= 12'(mw);
    max_height <= 12'(mh);
    @(posedge ref_clk);
  endtask

  task automatic send_field(input logic f, input int w, h);
    int x, y, n, cw, ch;
    logic [23:0] p;
    n = words;
    fid_now = f;
    exp_q.push_back(expd(f, w, h));
    cw = (max_width != 0 && w > max_width) ? max_width : w;
    ch = (max_height != 0 && h > max_height) ? max_height : h;
    for (y = 0; y < h; y++)
      for (x = 0; x < w; x++)
      begin
        p = 24'($urandom);
        if (x < cw && y < ch)
          wq.push_back({12'(x), 12'(y), p});
        src_valid <= 1'b1;
        src_beat <= '{pixel: p, sof: (x == 0 && y == 0),
                      eol: (x == w - 1), field_identifier: f};
        do @(posedge ref_clk); while (src_ready !== 1'b1);
      end
    src_valid <= 1'b0;
    for (x = 0; x < 300 && words - n < cw * ch; x++) @(posedge ref_clk);
    chk(48'(words - n), 48'(cw * ch), "words");
    chk(parser_field_identifier, f, "parser");
  endtask

  initial
  begin
    src_valid = 1'b0;
    src_beat = '0;
    interlaced = 1'b1;
    csc_mode = vcf_pkg::VCF_CSC_BYPASS;
    max_width = 12'h000;
    max_height = 12'h000;
    slow = 1'b0;
    rst = 1'b1;
    void'($urandom(49));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    // Bypass, no limit, repeated identifier in the middle
    send_field(1, 3, 2);
    send_field(0, 3, 2);
    send_field(0, 3, 2);
    send_field(1, 3, 2);
    $display("test bypass done");
    // Limits: oversize, exact boundary, width only, progressive
    cfg(1, 0, 4, 3);
    send_field(1, 6, 5);
    send_field(1, 4, 3);
    send_field(1, 5, 3);
    cfg(0, 0, 4, 3);
    send_field(1, 6, 5);
    $display("test clip done");
    // Every converter mode except bypass
    for (int m = 1; m < 4; m++)
    begin
      cfg(1, m, 0, 0);
      send_field(1, 2, 2);
    end
    $display("test converter done");
    // Random fields with memory stalls
    slow <= 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      cfg($urandom, $urandom_range(0, 3) == 0 ? $urandom_range(1, 3) : 0,
          $urandom_range(0, 6), $urandom_range(0, 4));
      send_field($urandom, $urandom_range(1, 7), $urandom_range(1, 5));
    end
    cfg(1, 0, 0, 0);
    send_field(0, 1, 1);
    repeat (5) @(posedge ref_clk);
    chk(exp_q.size(), 1, "descriptors");
    chk(wq.size(), 0, "leftover words");
    $display("test random done");
    summarize();
  end
endmodule
